// *** logic/rmsl_pkg.sv ***
package rmsl_pkg;

    // data bus width and mode select line positions
    localparam int DATA_W        = 16;
    localparam int BOOT_W_BIT    = 0;
    localparam int GRP0_BIT      = 1;
    localparam int GRP1_BIT      = 2;
    localparam int ADDR_LO_BIT   = 3;
    localparam int ADDR_HI_BIT   = 7;
    localparam int NUM_ADDR_CS   = ADDR_HI_BIT - ADDR_LO_BIT + 1;
    localparam int CTRL_PORT_BIT = 8;
    localparam int IRQ_PORT_BIT  = 9;
    localparam int TEST_BIT      = 11;

    // reset pin timing, in system clock output cycles
    localparam int DRIVE_CYCLES     = 512;
    localparam int FLOAT_CYCLES     = 10;
    localparam int FIRST_BUS_CYCLES = 10;
    localparam int CNT_W            = 10;
    localparam logic [CNT_W-1:0] DRIVE_LAST = CNT_W'(DRIVE_CYCLES - 1);
    localparam logic [CNT_W-1:0] FLOAT_LAST = CNT_W'(FLOAT_CYCLES - 1);
    localparam logic [CNT_W-1:0] BUS_LAST   = CNT_W'(FIRST_BUS_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO   = 10'h000;

    // reset values
    localparam logic [DATA_W-1:0]      DATA_PULLUP_ALL = 16'hffff;
    localparam logic [23:0]            RESET_VECTOR_ADDR = 24'h000000;
    localparam logic [2:0]             FC_SUPER_PROGRAM  = 3'h6;
    localparam logic [NUM_ADDR_CS-1:0] ADDR_EN_NONE      = 5'h00;

    typedef enum logic [2:0] {
        ST_DRIVE = 3'h1,
        ST_FLOAT = 3'h2,
        ST_RUN   = 3'h4
    } rmsl_state_type;

endpackage

// *** logic/rmsl_sync3.sv ***
// three-stage synchroniser; output moves only when stages two and three agree
module rmsl_sync3 #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // pin side
    input  wire logic [W-1:0] async_in,
    // clock side
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } rmsl_sync_type;

    rmsl_sync_type sync_reg;
    rmsl_sync_type sync_next;

    always_comb begin
        sync_next     = sync_reg;
        sync_next.s1  = async_in;
        sync_next.s2  = sync_reg.s1;
        sync_next.s3  = sync_reg.s2;
        // per bit: a change counts only once it is seen twice
        sync_next.val = (sync_reg.s2 & sync_reg.s3) | (sync_reg.val & (sync_reg.s2 | sync_reg.s3));
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.val;
endmodule

// *** logic/rmsl_mode_latch.sv ***
// Summary of operation
// R1 - weak pull-up on every data line
// R2 - partner releases data bus before first cycle
// R3 - boot chip select active at reset release
// R4 - vectors fetched from address zero, supervisor program
// R5 - boot line low 8-bit, high 16-bit
// R6 - two lines pick chip select group functions
// R7 - lines 3-7 low turn selects into address
// R8 - control line low gives port E
// R9 - interrupt line low gives port F
// R10 - test line picks factory test mode
// R11 - clock pin high synthesizer, low external clock
// R12 - partner drives clock pin actively in reset
// R13 - breakpoint low at release sets debug flag
// R14 - both high gives breakpoint exception later
// R15 - module pins come out as inputs
// R16 - pins inactive while reset asserted
// R17 - after release inputs float, outputs run
// R18 - drive 512, float ten, test, repeat
// R19 - samples held until next reset
module rmsl_mode_latch
    import rmsl_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    // mode select pins
    input  wire logic [DATA_W-1:0]      data_in,
    output logic      [DATA_W-1:0]      data_pullup_en,
    input  wire logic                   clock_source_select_pin,
    input  wire logic                   breakpoint_request_ext_n,
    input  wire logic                   breakpoint_request_int_n,
    // bidirectional reset pin
    input  wire logic                   reset_pin_in,
    output logic                        reset_pin_out,
    output logic                        reset_pin_oe,
    // captured configuration
    output logic                        boot_port_16bit,
    output logic                        cs_group0_alt,
    output logic                        cs_group1_alt,
    output logic      [NUM_ADDR_CS-1:0] cs_as_address,
    output logic                        control_pins_port_e,
    output logic                        irq_pins_port_f,
    output logic                        test_mode,
    output logic                        clock_from_synth,
    output logic                        background_debug_mode,
    // pin and module state
    output logic                        boot_chip_select_n,
    output logic                        integ_pins_drive_en,
    output logic                        module_pin_func_en,
    output logic                        module_port_dir_out,
    // reset exception and breakpoints
    output logic                        first_bus_cycle_ok,
    output logic                        vector_fetch_req,
    output logic      [23:0]            vector_addr,
    output logic      [2:0]             vector_fc,
    output logic                        debug_entry,
    output logic                        brk_exception
);
    typedef struct packed {
        rmsl_state_type         st;
        logic [CNT_W-1:0]       cnt;
        logic                   active;
        logic                   bus_ok;
        logic                   boot16;
        logic                   grp0;
        logic                   grp1;
        logic [NUM_ADDR_CS-1:0] addr_en;
        logic                   porte;
        logic                   portf;
        logic                   test;
        logic                   synth;
        logic                   dbg;
        logic                   bk_prev;
        logic                   vec_pulse;
        logic                   dbg_pulse;
        logic                   exc_pulse;
    } rmsl_latch_type;

    rmsl_latch_type r_reg;
    rmsl_latch_type r_next;

    logic [DATA_W-1:0] data_f;
    logic              clk_sel_f;
    logic              bk_ext_f;
    logic              rst_f;
    logic              bk_now;
    logic              release_now;

    // pins default high so an undriven line reads as the default option
    rmsl_sync3 #(.W(DATA_W), .RST_VAL(DATA_PULLUP_ALL)) u_sync_data (
        .mclk     (mclk),
        .rstn     (rstn),
        .async_in (data_in),
        .sync_out (data_f)
    );

    rmsl_sync3 #(.W(3), .RST_VAL(3'h7)) u_sync_ctl (
        .mclk     (mclk),
        .rstn     (rstn),
        .async_in ({clock_source_select_pin, breakpoint_request_ext_n, reset_pin_in}),
        .sync_out ({clk_sel_f, bk_ext_f, rst_f})
    );

    // chip select k (6 + i) is an address line if any line i+3..7 is low
    function automatic logic [NUM_ADDR_CS-1:0] addr_map(input logic [DATA_W-1:0] d);
        logic [NUM_ADDR_CS-1:0] m;
        m = ADDR_EN_NONE;
        for (int i = 0; i < NUM_ADDR_CS; i++) begin
            for (int j = i; j < NUM_ADDR_CS; j++) begin
                m[i] = m[i] | ~d[ADDR_LO_BIT + j];
            end
        end
        return m;
    endfunction

    assign bk_now      = ~(breakpoint_request_int_n & bk_ext_f);
    assign release_now = (r_reg.st == ST_FLOAT) && (r_reg.cnt == FLOAT_LAST) && rst_f;

    always_comb begin
        r_next           = r_reg;
        r_next.cnt       = r_reg.cnt + 10'h001;
        r_next.vec_pulse = 1'b0;
        r_next.dbg_pulse = 1'b0;
        r_next.exc_pulse = 1'b0;
        r_next.bk_prev   = bk_now;
        case (r_reg.st)
            ST_DRIVE: begin
                if (r_reg.cnt == DRIVE_LAST) begin // R18
                    r_next.st  = ST_FLOAT;
                    r_next.cnt = CNT_ZERO;
                end
            end
            ST_FLOAT: begin
                if (r_reg.cnt == FLOAT_LAST) begin
                    r_next.cnt = CNT_ZERO;
                    if (rst_f) begin
                        // capture once; nothing below touches these until the next reset
                        r_next.st      = ST_RUN; // R19
                        r_next.active  = 1'b1; // R3 R17
                        r_next.boot16  = data_f[BOOT_W_BIT]; // R5
                        r_next.grp0    = ~data_f[GRP0_BIT]; // R6
                        r_next.grp1    = ~data_f[GRP1_BIT]; // R6
                        r_next.addr_en = addr_map(data_f); // R7
                        r_next.porte   = ~data_f[CTRL_PORT_BIT]; // R8
                        r_next.portf   = ~data_f[IRQ_PORT_BIT]; // R9
                        r_next.test    = ~data_f[TEST_BIT]; // R10
                        r_next.synth   = clk_sel_f; // R11
                        r_next.dbg     = bk_now; // R13 R14
                    end else begin
                        r_next.st = ST_DRIVE; // R18
                    end
                end
            end
            ST_RUN: begin
                if (!r_reg.bus_ok && r_reg.cnt == BUS_LAST) begin
                    r_next.bus_ok    = 1'b1; // R2
                    r_next.vec_pulse = 1'b1; // R4
                end
                if (r_reg.bus_ok) begin
                    r_next.cnt = r_reg.cnt;
                end
                if (bk_now && !r_reg.bk_prev) begin
                    r_next.dbg_pulse = r_reg.dbg; // R13
                    r_next.exc_pulse = ~r_reg.dbg; // R14
                end
                // external reset: back to driving the pin, pins inactive again
                if (!rst_f) begin
                    r_next.st     = ST_DRIVE; // R16
                    r_next.cnt    = CNT_ZERO;
                    r_next.active = 1'b0;
                    r_next.bus_ok = 1'b0;
                    // no pulse may leave once the pin is seen low
                    r_next.vec_pulse = 1'b0; // R16
                    r_next.dbg_pulse = 1'b0; // R16
                    r_next.exc_pulse = 1'b0; // R16
                end
            end
            default: begin
                r_next.st  = ST_DRIVE;
                r_next.cnt = CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '{st: ST_DRIVE, cnt: CNT_ZERO, boot16: 1'b1, synth: 1'b1, addr_en: ADDR_EN_NONE,
                       bk_prev: 1'b1, default: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign data_pullup_en        = DATA_PULLUP_ALL; // R1
    assign reset_pin_out         = 1'b0;
    assign reset_pin_oe          = (r_reg.st == ST_DRIVE); // R18
    assign boot_port_16bit       = r_reg.boot16;
    assign cs_group0_alt         = r_reg.grp0;
    assign cs_group1_alt         = r_reg.grp1;
    assign cs_as_address         = r_reg.addr_en;
    assign control_pins_port_e   = r_reg.porte;
    assign irq_pins_port_f       = r_reg.portf;
    assign test_mode             = r_reg.test;
    assign clock_from_synth      = r_reg.synth;
    assign background_debug_mode = r_reg.dbg;
    assign boot_chip_select_n    = ~r_reg.active; // R3
    assign integ_pins_drive_en   = r_reg.active; // R16 R17
    // module pins: function off, direction input; other logic may change them later
    assign module_pin_func_en    = 1'b0; // R15
    assign module_port_dir_out   = 1'b0; // R15
    assign first_bus_cycle_ok    = r_reg.bus_ok;
    assign vector_fetch_req      = r_reg.vec_pulse;
    assign vector_addr           = RESET_VECTOR_ADDR; // R4
    assign vector_fc             = FC_SUPER_PROGRAM; // R4
    assign debug_entry           = r_reg.dbg_pulse;
    assign brk_exception         = r_reg.exc_pulse;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence release_s;
        release_now;
    endsequence

    sequence bk_edge_s;
        r_reg.active && bk_now && !r_reg.bk_prev;
    endsequence

    drive_low_a: assert property (reset_pin_oe |-> !reset_pin_out && boot_chip_select_n) // R18
        else $error("reset pin not driven low in drive phase");
    float_retest_a: assert property ((r_reg.st == ST_FLOAT && r_reg.cnt == FLOAT_LAST && !rst_f) // R18
        |=> reset_pin_oe && r_reg.cnt == CNT_ZERO)
        else $error("low reset pin after float did not restart drive");
    release_pins_a: assert property (release_s |=> !boot_chip_select_n && integ_pins_drive_en) // R3
        else $error("boot select or pins not active after release");
    boot_width_a: assert property (release_s |=> boot_port_16bit == $past(data_f[BOOT_W_BIT])) // R5
        else $error("boot port width does not follow sampled line");
    addr_map_a: assert property (release_s |=> cs_as_address == addr_map($past(data_f))) // R7
        else $error("address select map wrong");
    ports_mode_a: assert property (release_s |=> control_pins_port_e == !$past(data_f[CTRL_PORT_BIT]) // R8
        && irq_pins_port_f == !$past(data_f[IRQ_PORT_BIT]) && clock_from_synth == $past(clk_sel_f))
        else $error("port or clock mode not captured");
    held_cfg_a: assert property ((r_reg.st == ST_RUN && $past(r_reg.st == ST_RUN)) // R19
        |-> $stable({boot_port_16bit, cs_as_address, test_mode, background_debug_mode, cs_group0_alt}))
        else $error("captured configuration changed after release");
    // ten quiet cycles kept as two short runs so the tools unroll little
    first_bus_a: assert property ($rose(r_reg.active) |-> // R2
        (!first_bus_cycle_ok)[*5] ##1 (!first_bus_cycle_ok)[*5] ##1
        (first_bus_cycle_ok && vector_fetch_req && vector_addr == RESET_VECTOR_ADDR))
        else $error("first bus cycle or vector fetch mistimed");
    brk_route_a: assert property (bk_edge_s |=> (debug_entry == $past(r_reg.dbg)) // R13
        && (brk_exception != debug_entry))
        else $error("breakpoint routed to the wrong handler");
    inactive_a: assert property (!r_reg.active |-> !integ_pins_drive_en && !debug_entry && !vector_fetch_req) // R16
        else $error("pins or actions active during reset");
endmodule

// *** verif/rmsl_cfg_partner.sv ***
module rmsl_cfg_partner
    import rmsl_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rstn,
    // wanted configuration
    input  wire logic [DATA_W-1:0] cfg_data,
    input  wire logic              cfg_clk,
    input  wire logic              hold_rst,
    // device side
    input  wire logic              boot_chip_select_n,
    input  wire logic              reset_pin_out,
    input  wire logic              reset_pin_oe,
    output logic      [DATA_W-1:0] data_in,
    output logic                   clock_source_select_pin,
    output logic                   reset_pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic driving;
    logic toggle = 1'b0;
    // let go as soon as release shows, well before the first bus cycle
    assign driving = !rstn || boot_chip_select_n;
    // released lines fall back to the pull-up level
    assign data_in = driving ? cfg_data : 16'hffff;
    always @(negedge mclk) begin
        toggle <= ~toggle;
    end
    // active driver in reset, port f traffic afterwards
    assign clock_source_select_pin = driving ? cfg_clk : toggle;
    // open reset line with pull-up, optionally held low from outside
    assign reset_pin_in = (reset_pin_oe ? reset_pin_out : 1'b1) & ~hold_rst;
endmodule

// *** verif/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import rmsl_pkg::*;
    logic                   mclk, rstn, clk_pin, cfg_clk, hold_rst, brk_ext_n, brk_int_n;
    logic [DATA_W-1:0]      data_in, pullup_en, cfg_data;
    logic                   rpin_in, rpin_out, rpin_oe, boot16, grp0, grp1, ctl_e, irq_f, tmode, synth, dbg_flag;
    logic                   bcs_n, integ_en, pfunc, pdir, fbus, vreq, dbg_entry, brk_exc;
    logic [NUM_ADDR_CS-1:0] cs_addr;
    logic [23:0]            vaddr;
    logic [2:0]             vfc;
    int                     err_total, n_tests;

    rmsl_mode_latch DUT (.mclk(mclk), .rstn(rstn), .data_in(data_in), .data_pullup_en(pullup_en),
        .clock_source_select_pin(clk_pin), .breakpoint_request_ext_n(brk_ext_n),
        .breakpoint_request_int_n(brk_int_n), .reset_pin_in(rpin_in), .reset_pin_out(rpin_out),
        .reset_pin_oe(rpin_oe), .boot_port_16bit(boot16), .cs_group0_alt(grp0), .cs_group1_alt(grp1),
        .cs_as_address(cs_addr), .control_pins_port_e(ctl_e), .irq_pins_port_f(irq_f), .test_mode(tmode),
        .clock_from_synth(synth), .background_debug_mode(dbg_flag), .boot_chip_select_n(bcs_n),
        .integ_pins_drive_en(integ_en), .module_pin_func_en(pfunc), .module_port_dir_out(pdir),
        .first_bus_cycle_ok(fbus), .vector_fetch_req(vreq), .vector_addr(vaddr), .vector_fc(vfc),
        .debug_entry(dbg_entry), .brk_exception(brk_exc));

    rmsl_cfg_partner partner (.mclk(mclk), .rstn(rstn), .cfg_data(cfg_data), .cfg_clk(cfg_clk),
        .hold_rst(hold_rst), .boot_chip_select_n(bcs_n), .reset_pin_out(rpin_out), .reset_pin_oe(rpin_oe),
        .data_in(data_in), .clock_source_select_pin(clk_pin), .reset_pin_in(rpin_in));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // chip select 6+i turns to address if any line from i+3 up to 7 is low
    function automatic logic [4:0] exp_addr(input logic [15:0] d);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 5; i++) begin
            for (int j = i; j < 5; j++) begin
                if (!d[j+3]) r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    task automatic check_cfg(input logic [15:0] d, input logic ck, input logic dbg);
        check("boot width", boot16, d[0]);
        check("groups", {grp1, grp0}, {!d[2], !d[1]});
        check("cs address", cs_addr, exp_addr(d));
        check("port e", ctl_e, !d[8]);
        check("port f", irq_f, !d[9]);
        check("test mode", tmode, !d[11]);
        check("clock source", synth, ck);
        check("debug flag", dbg_flag, dbg);
        check("pins out", {integ_en, pfunc, pdir}, 3'h4);
    endtask

    // count the pulse kinds over a short window after one breakpoint
    task automatic brk_try(input bit ext, input logic dbg);
        int nb, ne;
        nb = 0;
        ne = 0;
        if (ext) brk_ext_n = 1'b0;
        else brk_int_n = 1'b0;
        for (int k = 0; k < 10; k++) begin
            @(negedge mclk);
            nb += int'(dbg_entry === 1'b1);
            ne += int'(brk_exc === 1'b1);
            if (k == 3) {brk_ext_n, brk_int_n} = 2'h3;
        end
        check("debug entries", nb, dbg ? 1 : 0);
        check("breakpoint_request exceptions", ne, dbg ? 0 : 1);
    endtask

    task automatic wait_oe(input logic lvl, output int n);
        n = 0;
        while (rpin_oe !== lvl && n < 2000) begin
            @(negedge mclk);
            n++;
        end
    endtask

    task automatic one_reset(input logic [15:0] d, input logic ck, input logic en, input logic in_,
                             input bit redrive);
        int nd, nf;
        cfg_data = d;
        cfg_clk = ck;
        brk_ext_n = en;
        brk_int_n = in_;
        hold_rst = redrive;
        rstn = 1'b0;
        repeat (16) @(negedge mclk);
        check("pin low in reset", {rpin_oe, rpin_out}, 2'h2);
        check("inactive pins", {bcs_n, integ_en}, 2'h2);
        check("pullups", pullup_en, 16'hffff);
        check("module pins", {pfunc, pdir}, 2'h0);
        rstn = 1'b1;
        wait_oe(1'b0, nd);
        check("drive span", nd inside {[511:513]}, 1'b1);
        if (redrive) begin
            wait_oe(1'b1, nf);
            check("float span", nf inside {[9:13]}, 1'b1);
            hold_rst = 1'b0;
            wait_oe(1'b0, nd);
            check("redrive span", nd inside {[511:513]}, 1'b1);
        end
        nf = 0;
        while (bcs_n !== 1'b0 && nf < 40) begin
            @(negedge mclk);
            nf++;
        end
        check("release span", nf inside {[9:13]}, 1'b1);
        check_cfg(d, ck, ~(en & in_));
        {brk_ext_n, brk_int_n} = 2'h3;
        nf = 0;
        while (fbus !== 1'b1 && nf < 40) begin
            @(negedge mclk);
            nf++;
        end
        check("first bus", nf inside {[9:11]}, 1'b1);
        check("vector req", vreq, 1'b1);
        check("vector space", {vaddr, vfc}, {24'h000000, 3'h6});
        @(negedge mclk);
        check("vector pulse", vreq, 1'b0);
        repeat (6) @(negedge mclk);
        brk_try(1'b0, ~(en & in_));
        brk_try(1'b1, ~(en & in_));
        check_cfg(d, ck, ~(en & in_));
        // pin pulled low while running: drive restarts, captured modes stay
        if (redrive) begin
            hold_rst = 1'b1;
            wait_oe(1'b1, nf);
            check("run redrive", {nf inside {[3:6]}, bcs_n, integ_en}, 3'h6);
            check("cfg kept", {boot16, cs_addr}, {d[0], exp_addr(d)});
            hold_rst = 1'b0;
        end
    endtask

    initial begin
        logic [15:0] d;
        err_total = 0;
        n_tests = 0;
        rstn = 1'b0;
        cfg_data = 16'hffff;
        cfg_clk = 1'b1;
        hold_rst = 1'b0;
        brk_ext_n = 1'b1;
        brk_int_n = 1'b1;
        void'($urandom(32'h0c87feb7));
        for (int it = 0; it < 7; it++) begin
            d = (it == 0) ? 16'hffff : (it == 1) ? 16'h0000 : 16'($urandom);
            one_reset(d, (it == 0) | ((it > 1) & 1'($urandom)), (it == 0) | ((it > 1) & 1'($urandom)),
                      it != 1, it == 2);
        end
        end_sim;
    end

    initial begin
        #200000;
        err_total++;
        $display("MISMATCH watchdog expected finish seen hang");
        end_sim;
    end
endmodule
